// File: hdl/sdp_pkg.sv
// Constants, types and helpers of the serial port delimiter packer.
//
// Contract
// - Frame 5-8 bits, 1/1.5/2 stop, five parities.
// - Flow none, XON/XOFF, RTS/CTS or DTR/DSR.
// - Line mode 422, 485 two-wire, 485 four-wire.
// - Throughput or latency performance mode.
// - Four delimiter bytes per direction.
// - Serial-to-network data held until delimiters/timeout.
// - Network-to-serial data held until delimiters/timeout.
// - Zero delimiter disables it; default zero.
// - Release only after all enabled delimiters match.
// - Full 4K buffer releases its data.
// - Flush timeout 0..65535 seconds releases data.
// - Forced interval without transmission sends data.
// - Transmit buffer sends when holding 4K.
// - Forced interval zero disables; default zero.
// - Up to five sessions, default one.
// - Idle timer closes first session; zero disables.
// - Keep-alive probe; failure closes; zero disables.
package sdp_pkg;
	localparam int CLK_HZ = 250_000_000;
	localparam int OVERSAMPLE = 16;
	localparam int TICK_S = 1;
	localparam int TICK_CYCLES = CLK_HZ * TICK_S;
	localparam int BUF_DEPTH = 4096;
	localparam int DEFAULT_BAUD = 38400;
	localparam logic [15:0] BAUD_DIV_RST =
		16'(CLK_HZ / (OVERSAMPLE * DEFAULT_BAUD));
	localparam int HIGH_MARK = BUF_DEPTH - 64;
	// ----------------------------------------------------------------
	// Register offsets and reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_BAUD = 8'h04;
	localparam logic [7:0] OFS_DELIM_S2N = 8'h08;
	localparam logic [7:0] OFS_DELIM_N2S = 8'h0C;
	localparam logic [7:0] OFS_FLUSH_S2N = 8'h10;
	localparam logic [7:0] OFS_FLUSH_N2S = 8'h14;
	localparam logic [7:0] OFS_FORCE = 8'h18;
	localparam logic [7:0] OFS_IDLE = 8'h1C;
	localparam logic [7:0] OFS_ALIVE = 8'h20;
	localparam logic [7:0] OFS_COUNT = 8'h24;
	localparam logic [7:0] OFS_FLAGS = 8'h28;
	localparam logic [31:0] CTRL_RST = 32'h0000_0803;
	localparam logic [31:0] DELIM_RST = 32'h0000_0000;
	localparam logic [15:0] TIME_RST = 16'h0000;
	localparam logic [2:0] SESS_MIN = 3'h1;
	localparam logic [2:0] SESS_MAX = 3'h5;
	localparam logic [2:0] SYNC_RST = 3'h1;
	localparam logic [4:0] OS_MID = 5'h07;
	localparam logic [4:0] OS_LAST = 5'h0F;
	localparam logic [4:0] OS_STOP15 = 5'h17;
	localparam logic [4:0] OS_STOP2 = 5'h1F;
	localparam logic [7:0] XON = 8'h11;
	localparam logic [7:0] XOFF = 8'h13;
	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {PAR_NONE = 3'h0, PAR_EVEN = 3'h1,
		PAR_ODD = 3'h2, PAR_MARK = 3'h3, PAR_SPACE = 3'h4} sdp_par_e;
	typedef enum logic [1:0] {FLOW_NONE = 2'h0, FLOW_XONXOFF = 2'h1,
		FLOW_RTSCTS = 2'h2, FLOW_DTRDSR = 2'h3} sdp_flow_e;
	typedef enum logic [1:0] {LINE_FULL = 2'h0, LINE_485_2W = 2'h1,
		LINE_485_4W = 2'h2} sdp_line_e;
	typedef enum logic [4:0] {TX_IDLE = 5'h01, TX_START = 5'h02,
		TX_DATA = 5'h04, TX_PAR = 5'h08, TX_STOP = 5'h10} sdp_tx_e;
	typedef enum logic [4:0] {RX_IDLE = 5'h01, RX_START = 5'h02,
		RX_DATA = 5'h04, RX_PAR = 5'h08, RX_STOP = 5'h10} sdp_rx_e;
	typedef struct packed {
		logic [17:0] rsvd;
		logic [2:0] sessions;
		logic latency;
		logic [1:0] line;
		logic [1:0] flow;
		logic [2:0] parity;
		logic stop2;
		logic [1:0] wlen;
	} sdp_ctrl_s;
	typedef struct packed {
		logic valid;
		logic [7:0] data;
	} sdp_byte_s;
	// Parity bit over the active word bits only.
	function automatic logic sdp_par(logic [2:0] p, logic [7:0] d,
		logic [1:0] wl);
		logic [7:0] m;
		m = d & (8'hFF >> (2'h3 - wl));
		case (p)
			PAR_EVEN: return ^m;
			PAR_ODD: return ~^m;
			PAR_MARK: return 1'b1;
			default: return 1'b0;
		endcase
	endfunction
	function automatic logic [3:0] sdp_dl_en(logic [31:0] dl);
		logic [3:0] en;
		for (int i = 0; i < 4; i++) begin
			en[i] = dl[8*i +: 8] != 8'h00;
		end
		return en;
	endfunction
	// Delimiters match in slot order; a miss restarts the search.
	function automatic logic [3:0] sdp_dl_step(logic [31:0] dl,
		logic [3:0] m, logic [7:0] b);
		logic [3:0] en;
		logic [3:0] r;
		logic found;
		logic first;
		en = sdp_dl_en(dl);
		r = m;
		found = 1'b0;
		first = 1'b0;
		for (int i = 0; i < 4; i++) begin
			if (en[i] && !m[i] && !found) begin
				found = 1'b1;
				if (dl[8*i +: 8] == b) begin
					r[i] = 1'b1;
				end else begin
					r = 4'h0;
					for (int j = 0; j < 4; j++) begin
						if (en[j] && !first) begin
							first = 1'b1;
							r[j] = dl[8*j +: 8] == b;
						end
					end
				end
			end
		end
		return r;
	endfunction
endpackage

// File: hdl/sdp_top.sv
// Serial port engine with two delimiter forwarding buffers.
//
// Register access over AHB-Lite and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module sdp_top #(
	parameter int DEPTH = sdp_pkg::BUF_DEPTH,
	parameter int TICK_CYCLES = sdp_pkg::TICK_CYCLES
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic rxd,
	input wire logic cts,
	input wire logic dsr,
	output logic txd,
	output logic txd_oe,
	output logic rxd_en,
	output logic rts,
	output logic dtr,
	input wire sdp_pkg::sdp_byte_s net_in,
	output logic net_in_ready,
	output var sdp_pkg::sdp_byte_s net_out,
	input wire logic net_out_ready,
	input wire logic sess_active,
	input wire logic alive_fail,
	output logic sess_close,
	output logic alive_probe,
	output logic [2:0] sess_max
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
	localparam logic [31:0] HIGH_CNT = 32'(sdp_pkg::HIGH_MARK);
	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [AW:0] wp;
		logic [AW:0] rp;
		logic [AW:0] relp;
		logic [3:0] mask;
		logic [15:0] fcnt;
	} sdp_buf_s;
	typedef struct packed {
		sdp_pkg::sdp_ctrl_s ctrl;
		logic [15:0] baud;
		logic [1:0][31:0] delim;
		logic [1:0][15:0] flush;
		logic [15:0] force_t;
		logic [15:0] idle_t;
		logic [15:0] alive_t;
		logic a_wr;
		logic [7:0] a_addr;
		logic [31:0] rdata;
		logic [2:0] sy0;
		logic [2:0] sy1;
		logic [2:0] sy2;
		logic [2:0] filt;
		logic [15:0] div_cnt;
		logic btick;
		logic [31:0] tcnt;
		logic ttick;
		sdp_buf_s [1:0] bufs;
		logic out_v;
		logic [7:0] out_d;
		sdp_pkg::sdp_tx_e tx_st;
		logic [7:0] tx_sh;
		logic tx_pb;
		logic [3:0] tx_bit;
		logic [4:0] tx_os;
		logic txd;
		logic paused;
		logic xoff_sent;
		sdp_pkg::sdp_rx_e rx_st;
		logic [7:0] rx_sh;
		logic [3:0] rx_bit;
		logic [4:0] rx_os;
		logic rx_perr;
		logic [15:0] fxcnt;
		logic [15:0] idcnt;
		logic [15:0] alcnt;
		logic close;
		logic probe;
	} sdp_st_s;
	sdp_st_s s;
	sdp_st_s n;
	logic [1:0] wv;
	logic [1:0][7:0] wb;
	logic [1:0][7:0] mem_rd;
	logic [1:0][AW:0] cnt;
	logic high;
	// ----------------------------------------------------------------
	// Buffer memories
	// ----------------------------------------------------------------
	for (genvar d = 0; d < 2; d++) begin : g_mem
		logic [7:0] mem [DEPTH];
		always_ff @(posedge hclk) begin
			if (wv[d]) begin
				mem[s.bufs[d].wp[AW-1:0]] <= wb[d];
			end
		end
		assign mem_rd[d] = mem[s.bufs[d].rp[AW-1:0]];
	end
	// Counts wrap at the pointer width, so they are kept at that width.
	assign cnt[0] = s.bufs[0].wp - s.bufs[0].rp;
	assign cnt[1] = s.bufs[1].wp - s.bufs[1].rp;
	// The mark is absolute, so a buffer smaller than it never throttles.
	assign high = 32'(cnt[0]) >= HIGH_CNT;
	assign net_in_ready = cnt[1] != FULL_CNT;
	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		sdp_pkg::sdp_ctrl_s c;
		logic rxin;
		logic rbv;
		logic [7:0] rb;
		logic [3:0] last;
		logic [4:0] stop_last;
		logic tx_ok;
		logic tx_go;
		logic [1:0] drn;
		logic [1:0] ext;
		logic [3:0] en;
		logic [3:0] nm;
		logic pend;
		logic hold;
		logic hit;
		logic full;
		logic expire;
		c = s.ctrl;
		rxin = 1'b1;
		rbv = 1'b0;
		rb = 8'h00;
		last = 4'h4 + {2'h0, c.wlen};
		stop_last = sdp_pkg::OS_LAST;
		tx_ok = 1'b1;
		tx_go = 1'b0;
		drn = 2'h0;
		ext = 2'h0;
		en = 4'h0;
		nm = 4'h0;
		pend = 1'b0;
		hold = 1'b0;
		hit = 1'b0;
		full = 1'b0;
		expire = 1'b0;
		n = s;
		wv = 2'h0;
		wb = {net_in.data, 8'h00};
		n.btick = 1'b0;
		if (s.div_cnt >= s.baud - 16'h0001) begin
			n.div_cnt = 16'h0000;
			n.btick = 1'b1;
		end else begin
			n.div_cnt = s.div_cnt + 16'h0001;
		end
		n.ttick = 1'b0;
		if (s.tcnt >= 32'(TICK_CYCLES - 1)) begin
			n.tcnt = 32'h0000_0000;
			n.ttick = 1'b1;
		end else begin
			n.tcnt = s.tcnt + 32'h0000_0001;
		end
		n.sy0 = {dsr, cts, rxd};
		n.sy1 = s.sy0;
		n.sy2 = s.sy1;
		n.filt = (s.sy1 & ~(s.sy1 ^ s.sy2)) | (s.filt & (s.sy1 ^ s.sy2));
		if (!(c.line == sdp_pkg::LINE_485_2W && s.tx_st != sdp_pkg::TX_IDLE)) begin
			rxin = s.filt[0];
		end
		if (c.stop2) begin
			stop_last = (c.wlen == 2'h0) ? sdp_pkg::OS_STOP15 : sdp_pkg::OS_STOP2;
		end
		// ------------------------------------------------------------
		// Receiver
		// ------------------------------------------------------------
		// Receive frame format
		if (s.btick) begin
			unique case (s.rx_st)
				sdp_pkg::RX_IDLE: begin
					if (!rxin) begin
						n.rx_st = sdp_pkg::RX_START;
						n.rx_os = 5'h00;
					end
				end
				sdp_pkg::RX_START: begin
					n.rx_os = s.rx_os + 5'h01;
					if (s.rx_os == sdp_pkg::OS_MID) begin
						n.rx_os = 5'h00;
						n.rx_bit = 4'h0;
						n.rx_perr = 1'b0;
						n.rx_st = rxin ? sdp_pkg::RX_IDLE : sdp_pkg::RX_DATA;
					end
				end
				sdp_pkg::RX_DATA: begin
					n.rx_os = s.rx_os + 5'h01;
					if (s.rx_os == sdp_pkg::OS_LAST) begin
						n.rx_os = 5'h00;
						n.rx_sh = {rxin, s.rx_sh[7:1]};
						n.rx_bit = s.rx_bit + 4'h1;
						if (s.rx_bit == last) begin
							n.rx_st = (c.parity == sdp_pkg::PAR_NONE) ?
								sdp_pkg::RX_STOP : sdp_pkg::RX_PAR;
						end
					end
				end
				sdp_pkg::RX_PAR: begin
					n.rx_os = s.rx_os + 5'h01;
					if (s.rx_os == sdp_pkg::OS_LAST) begin
						n.rx_os = 5'h00;
						n.rx_perr = rxin != sdp_pkg::sdp_par(c.parity,
							s.rx_sh >> (2'h3 - c.wlen), c.wlen);
						n.rx_st = sdp_pkg::RX_STOP;
					end
				end
				sdp_pkg::RX_STOP: begin
					n.rx_os = s.rx_os + 5'h01;
					if (s.rx_os == sdp_pkg::OS_LAST) begin
						n.rx_st = sdp_pkg::RX_IDLE;
						rbv = rxin && !s.rx_perr;
						rb = s.rx_sh >> (2'h3 - c.wlen);
					end
				end
			endcase
		end
		if (rbv && c.flow == sdp_pkg::FLOW_XONXOFF &&
			(rb == sdp_pkg::XON || rb == sdp_pkg::XOFF)) begin
			n.paused = rb == sdp_pkg::XOFF;
			rbv = 1'b0;
		end
		// Bytes arriving at a full buffer are lost; flow control prevents it.
		wv[0] = rbv && ((s.bufs[0].wp - s.bufs[0].rp) != FULL_CNT);
		wb[0] = rb;
		wv[1] = net_in.valid && net_in_ready;
		// ------------------------------------------------------------
		// Transmitter
		// ------------------------------------------------------------
		// Transmit permission
		unique case (c.flow)
			sdp_pkg::FLOW_RTSCTS: tx_ok = s.filt[1];
			sdp_pkg::FLOW_DTRDSR: tx_ok = s.filt[2];
			sdp_pkg::FLOW_XONXOFF: tx_ok = !s.paused;
			default: tx_ok = 1'b1;
		endcase
		if (s.btick) begin
			unique case (s.tx_st)
				sdp_pkg::TX_IDLE: begin
					if (c.flow == sdp_pkg::FLOW_XONXOFF && high != s.xoff_sent) begin
						tx_go = 1'b1;
						n.tx_sh = high ? sdp_pkg::XOFF : sdp_pkg::XON;
						n.xoff_sent = high;
					end else if (tx_ok && s.bufs[1].rp != s.bufs[1].relp) begin
						tx_go = 1'b1;
						n.tx_sh = mem_rd[1];
						drn[1] = 1'b1;
					end
					if (tx_go) begin
						n.tx_pb = sdp_pkg::sdp_par(c.parity, n.tx_sh, c.wlen);
						n.tx_st = sdp_pkg::TX_START;
						n.txd = 1'b0;
						n.tx_os = 5'h00;
					end
				end
				sdp_pkg::TX_START: begin
					n.tx_os = s.tx_os + 5'h01;
					if (s.tx_os == sdp_pkg::OS_LAST) begin
						n.tx_os = 5'h00;
						n.tx_bit = 4'h0;
						n.tx_st = sdp_pkg::TX_DATA;
						n.txd = s.tx_sh[0];
					end
				end
				sdp_pkg::TX_DATA: begin
					n.tx_os = s.tx_os + 5'h01;
					if (s.tx_os == sdp_pkg::OS_LAST) begin
						n.tx_os = 5'h00;
						n.tx_bit = s.tx_bit + 4'h1;
						n.tx_sh = s.tx_sh >> 1;
						n.txd = s.tx_sh[1];
						if (s.tx_bit == last) begin
							n.tx_st = (c.parity == sdp_pkg::PAR_NONE) ?
								sdp_pkg::TX_STOP : sdp_pkg::TX_PAR;
							n.txd = (c.parity == sdp_pkg::PAR_NONE) ? 1'b1 : s.tx_pb;
						end
					end
				end
				sdp_pkg::TX_PAR: begin
					n.tx_os = s.tx_os + 5'h01;
					if (s.tx_os == sdp_pkg::OS_LAST) begin
						n.tx_os = 5'h00;
						n.tx_st = sdp_pkg::TX_STOP;
						n.txd = 1'b1;
					end
				end
				sdp_pkg::TX_STOP: begin
					n.tx_os = s.tx_os + 5'h01;
					if (s.tx_os == stop_last) begin
						n.tx_st = sdp_pkg::TX_IDLE;
					end
				end
			endcase
		end
		// The output byte is registered so the stack sees stable data.
		if (net_out_ready) begin
			n.out_v = 1'b0;
		end
		if ((!s.out_v || net_out_ready) && s.bufs[0].rp != s.bufs[0].relp) begin
			n.out_v = 1'b1;
			n.out_d = mem_rd[0];
			drn[0] = 1'b1;
		end
		// ------------------------------------------------------------
		// Forwarding buffers
		// ------------------------------------------------------------
		// Forced transmit interval
		pend = s.bufs[1].wp != s.bufs[1].relp;
		if (tx_go || !pend) begin
			n.fxcnt = sdp_pkg::TIME_RST;
		end else if (s.ttick && s.fxcnt != 16'hFFFF) begin
			n.fxcnt = s.fxcnt + 16'h0001;
		end
		ext[1] = pend && s.force_t != 16'h0000 && s.fxcnt >= s.force_t;
		for (int d = 0; d < 2; d++) begin
			pend = s.bufs[d].wp != s.bufs[d].relp;
			en = sdp_pkg::sdp_dl_en(s.delim[d]);
			if (wv[d]) begin
				n.bufs[d].wp = s.bufs[d].wp + 1'b1;
			end
			if (drn[d]) begin
				n.bufs[d].rp = s.bufs[d].rp + 1'b1;
			end
			nm = wv[d] ? sdp_pkg::sdp_dl_step(s.delim[d], s.bufs[d].mask,
				wb[d]) : s.bufs[d].mask;
			hold = !c.latency && (s.flush[d] != 16'h0000 ||
				(d == 1 && s.force_t != 16'h0000));
			hit = wv[d] && ((en == 4'h0) ? !hold : ((nm | ~en) == 4'hF));
			full = (n.bufs[d].wp - n.bufs[d].rp) == FULL_CNT;
			expire = pend && s.flush[d] != 16'h0000 &&
				s.bufs[d].fcnt >= s.flush[d];
			if (hit || full || expire || ext[d]) begin
				n.bufs[d].relp = n.bufs[d].wp;
			end
			n.bufs[d].mask = (hit || en == 4'h0) ? 4'h0 : nm;
			if (wv[d] || !pend) begin
				n.bufs[d].fcnt = sdp_pkg::TIME_RST;
			end else if (s.ttick && s.bufs[d].fcnt != 16'hFFFF) begin
				n.bufs[d].fcnt = s.bufs[d].fcnt + 16'h0001;
			end
		end
		// ------------------------------------------------------------
		// Session timers
		// ------------------------------------------------------------
		n.close = 1'b0;
		n.probe = 1'b0;
		if (wv[0] || tx_go || !sess_active) begin
			n.idcnt = sdp_pkg::TIME_RST;
		end else if (s.ttick && s.idcnt != 16'hFFFF) begin
			n.idcnt = s.idcnt + 16'h0001;
		end
		if (sess_active && s.idle_t != 16'h0000 && s.idcnt >= s.idle_t) begin
			n.close = 1'b1;
			n.idcnt = sdp_pkg::TIME_RST;
		end
		if (!sess_active) begin
			n.alcnt = sdp_pkg::TIME_RST;
		end else if (s.ttick && s.alive_t != 16'h0000) begin
			n.alcnt = s.alcnt + 16'h0001;
		end
		if (sess_active && s.alive_t != 16'h0000 && s.alcnt >= s.alive_t) begin
			n.probe = 1'b1;
			n.alcnt = sdp_pkg::TIME_RST;
		end
		if (sess_active && alive_fail) begin
			n.close = 1'b1;
		end
		// ------------------------------------------------------------
		// Register bus
		// ------------------------------------------------------------
		if (s.a_wr) begin
			case (s.a_addr)
				sdp_pkg::OFS_CTRL: begin
					n.ctrl = sdp_pkg::sdp_ctrl_s'(hwdata);
					n.ctrl.rsvd = 18'h00000;
					if (n.ctrl.sessions < sdp_pkg::SESS_MIN) begin
						n.ctrl.sessions = sdp_pkg::SESS_MIN;
					end else if (n.ctrl.sessions > sdp_pkg::SESS_MAX) begin
						n.ctrl.sessions = sdp_pkg::SESS_MAX;
					end
				end
				sdp_pkg::OFS_BAUD: n.baud = (hwdata[15:0] == 16'h0000) ?
					16'h0001 : hwdata[15:0];
				sdp_pkg::OFS_DELIM_S2N: n.delim[0] = hwdata;
				sdp_pkg::OFS_DELIM_N2S: n.delim[1] = hwdata;
				sdp_pkg::OFS_FLUSH_S2N: n.flush[0] = hwdata[15:0];
				sdp_pkg::OFS_FLUSH_N2S: n.flush[1] = hwdata[15:0];
				sdp_pkg::OFS_FORCE: n.force_t = hwdata[15:0];
				sdp_pkg::OFS_IDLE: n.idle_t = hwdata[15:0];
				sdp_pkg::OFS_ALIVE: n.alive_t = hwdata[15:0];
				default: ;
			endcase
		end
		n.a_wr = 1'b0;
		if (hsel && htrans[1] && hready) begin
			n.a_wr = hwrite;
			n.a_addr = haddr[7:0];
			// Read data comes from the next state, so a write just ahead is seen.
			if (!hwrite) begin
				case (haddr[7:0])
					sdp_pkg::OFS_CTRL: n.rdata = n.ctrl;
					sdp_pkg::OFS_BAUD: n.rdata = {16'h0000, n.baud};
					sdp_pkg::OFS_DELIM_S2N: n.rdata = n.delim[0];
					sdp_pkg::OFS_DELIM_N2S: n.rdata = n.delim[1];
					sdp_pkg::OFS_FLUSH_S2N: n.rdata = {16'h0000, n.flush[0]};
					sdp_pkg::OFS_FLUSH_N2S: n.rdata = {16'h0000, n.flush[1]};
					sdp_pkg::OFS_FORCE: n.rdata = {16'h0000, n.force_t};
					sdp_pkg::OFS_IDLE: n.rdata = {16'h0000, n.idle_t};
					sdp_pkg::OFS_ALIVE: n.rdata = {16'h0000, n.alive_t};
					sdp_pkg::OFS_COUNT: n.rdata = {
						16'(cnt[1]),
						16'(cnt[0])};
					sdp_pkg::OFS_FLAGS: n.rdata = {29'h0000_0000, s.xoff_sent,
						s.paused, s.tx_st != sdp_pkg::TX_IDLE};
					default: n.rdata = 32'h0000_0000;
				endcase
			end
		end
	end
	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s <= '0;
			s.ctrl <= sdp_pkg::CTRL_RST;
			s.baud <= sdp_pkg::BAUD_DIV_RST;
			s.sy0 <= sdp_pkg::SYNC_RST;
			s.sy1 <= sdp_pkg::SYNC_RST;
			s.sy2 <= sdp_pkg::SYNC_RST;
			s.filt <= sdp_pkg::SYNC_RST;
			s.tx_st <= sdp_pkg::TX_IDLE;
			s.rx_st <= sdp_pkg::RX_IDLE;
			s.txd <= 1'b1;
		end else begin
			s <= n;
		end
	end
	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = s.rdata;
	assign txd = s.txd;
	assign txd_oe = s.ctrl.line == sdp_pkg::LINE_FULL ||
		s.tx_st != sdp_pkg::TX_IDLE;
	assign rxd_en = !(s.ctrl.line == sdp_pkg::LINE_485_2W &&
		s.tx_st != sdp_pkg::TX_IDLE);
	assign rts = s.ctrl.flow != sdp_pkg::FLOW_RTSCTS || !high;
	assign dtr = s.ctrl.flow != sdp_pkg::FLOW_DTRDSR || !high;
	assign net_out = '{valid: s.out_v, data: s.out_d};
	assign sess_close = s.close;
	assign alive_probe = s.probe;
	assign sess_max = s.ctrl.sessions;
endmodule
`default_nettype wire

// File: testbench/sdp_props.sv
// Port checks of the delimiter packer, bound to its top module.
`timescale 1ns/1ps
`default_nettype none
module sdp_props #(
	parameter int DEPTH = sdp_pkg::BUF_DEPTH
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic txd,
	input wire logic txd_oe,
	input wire logic rxd_en,
	input wire logic rts,
	input wire logic dtr,
	input wire sdp_pkg::sdp_byte_s net_out,
	input wire logic net_out_ready,
	input wire logic sess_close,
	input wire logic alive_probe,
	input wire logic [2:0] sess_max
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// Any line level lasts a full bit; s_space and s_mark check at least eight clocks.
	sequence s_space;
		(!txd) [*8];
	endsequence
	sequence s_mark;
		txd [*8];
	endsequence
	sequence s_stall;
		net_out.valid && !net_out_ready;
	endsequence
	a_drive_on: assert property (!txd |-> txd_oe)
		else $error("line driven low with driver off");
	a_rx_off: assert property (!rxd_en |-> txd_oe)
		else $error("receiver off while not sending");
	a_start_len: assert property ($fell(txd) |-> s_space)
		else $error("start bit too short");
	a_stop_high: assert property ($rose(txd) |-> s_mark)
		else $error("mark bit too short");
	a_out_hold: assert property (s_stall |=> net_out.valid &&
		$stable(net_out.data))
		else $error("output byte changed while stalled");
	// Only a nearly full buffer may withdraw permission.
	a_flow_ready: assert property ((DEPTH < 4032) |-> rts && dtr)
		else $error("permission dropped below high mark");
	a_sess_range: assert property (sess_max inside {[3'h1:3'h5]})
		else $error("session count out of range");
	a_close_pulse: assert property (sess_close |=> !sess_close)
		else $error("close longer than one cycle");
	a_probe_pulse: assert property (alive_probe |=> !alive_probe)
		else $error("probe longer than one cycle");
endmodule
`default_nettype wire

// File: testbench/sdp_dev.sv
// Serial peer that sends and frames characters on the line.
`timescale 1ns/1ps
`default_nettype none
module sdp_dev #(
	parameter int BIT = 32
) (
	input wire logic hclk,
	input wire logic line_in,
	output logic rxd,
	output logic cts,
	output logic dsr
);
	int nb = 9;
	int n_rx = 0;
	int rx_q[$];
	initial begin
		rxd = 1'b1;
		cts = 1'b1;
		dsr = 1'b1;
	end
	task automatic hold(input logic c, input logic s);
		cts <= c;
		dsr <= s;
	endtask
	task automatic send(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			rxd <= f[i];
			repeat (BIT) @(posedge hclk);
		end
	endtask
	always begin
		int v;
		@(negedge line_in);
		repeat (BIT / 2) @(posedge hclk);
		v = 0;
		for (int i = 0; i < nb; i++) begin
			repeat (BIT) @(posedge hclk);
			v[i] = line_in;
		end
		rx_q.push_back(v);
		n_rx++;
	end
endmodule
`default_nettype wire

// File: testbench/serial_port_delimiter_packer_tb.sv
// Self-checking bench of the delimiter packer against a serial peer.
`timescale 1ns/1ps
`default_nettype none
module serial_port_delimiter_packer_tb;
	localparam int DEPTH = 16;
	localparam logic [7:0] RA [5] = '{8'h00, 8'h04, 8'h08, 8'h18, 8'h2C};
	localparam logic [31:0] RV [5] = '{32'h803,
		32'(sdp_pkg::BAUD_DIV_RST), 32'h0, 32'h0, 32'h0};
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic net_out_ready = 1'b0;
	logic sess_active = 1'b0;
	logic alive_fail = 1'b0;
	logic hreadyout, hresp, txd, txd_oe, rxd_en, rts, dtr, rxd, cts, dsr;
	logic net_in_ready, sess_close, alive_probe, line, pb;
	logic [2:0] sess_max;
	logic [31:0] hrdata, rd, d, m;
	logic [31:0] seed = 32'h0000_0F2E;
	sdp_pkg::sdp_byte_s net_in = 9'h000;
	sdp_pkg::sdp_byte_s net_out;
	int error_cnt = 0;
	int n_checks = 0;
	int got = 0;
	int cyc = 0;
	int w, nb;
	int exp_q[$];
	always #2 hclk = ~hclk;
	// A released driver reads as idle mark through the line bias.
	assign line = txd_oe ? txd : 1'b1;
	sdp_top #(.DEPTH(DEPTH), .TICK_CYCLES(10)) dut_u (.hclk(hclk),
		.hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .rxd(rxd),
		.cts(cts), .dsr(dsr), .txd(txd), .txd_oe(txd_oe), .rxd_en(rxd_en),
		.rts(rts), .dtr(dtr), .net_in(net_in), .net_in_ready(net_in_ready),
		.net_out(net_out), .net_out_ready(net_out_ready),
		.sess_active(sess_active), .alive_fail(alive_fail),
		.sess_close(sess_close), .alive_probe(alive_probe),
		.sess_max(sess_max));
	sdp_dev #(.BIT(32)) dev_u (.hclk(hclk), .line_in(line), .rxd(rxd),
		.cts(cts), .dsr(dsr));
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("unexpected at %0t: got %h want %h", $time, g, e);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] v, output logic [31:0] r);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		hwrite <= w;
		hsize <= 3'h2;
		htrans <= 2'h2;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= v;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		r = hrdata;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		bus(1'b1, a, v, rd);
	endtask
	task automatic put(input logic [7:0] b);
		net_in <= {1'b1, b};
		do @(posedge hclk); while (net_in_ready !== 1'b1);
		net_in <= 9'h000;
	endtask
	// The sink stalls at random so released bytes must wait.
	always @(posedge hclk) begin
		cyc++;
		net_out_ready <= ^rnd();
		if (hresetn && net_out.valid === 1'b1 && net_out_ready) begin
			chk(32'(net_out.data), exp_q.pop_front());
			got++;
		end
		if (cyc == 60000) begin
			error_cnt++;
			give_verdict();
		end
	end
	initial begin
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		for (int i = 0; i < 5; i++) begin
			bus(1'b0, RA[i], 32'h0, rd);
			chk(rd, RV[i]);
		end
		wr(8'h00, 32'h0000_3803);
		bus(1'b0, 8'h00, 32'h0, rd);
		chk(rd, 32'h0000_2803);
		chk(32'(sess_max), 32'h5);
		wr(8'h04, 32'h2);
		$display("registers done");
		for (int p = 0; p < 5; p++) begin
			w = p % 4 + 5;
			d = rnd();
			m = d & 32'((1 << w) - 1);
			pb = (p == 1) ? ^m : (p == 2) ? ~^m : (p == 3);
			nb = w + (p != 0) + 1;
			wr(8'h00, 32'(p % 4 + (p > 2) * 4 + p * 8 + (p % 4) * 64 +
				(p % 3) * 256) | 32'hC00);
			dev_u.nb = nb;
			// Only the input of the chosen flow mode may hold the sender.
			dev_u.hold(p != 2, p != 3);
			repeat (6) @(posedge hclk);
			put(d[7:0]);
			if (p == 2 || p == 3) begin
				repeat (200) @(posedge hclk);
				bus(1'b0, 8'h28, 32'h0, rd);
				chk(rd, 32'h0);
				dev_u.hold(1'b1, 1'b1);
			end
			for (int i = 0; i < 9000 && dev_u.n_rx <= p; i++) @(posedge hclk);
			chk(dev_u.rx_q.pop_front(), m | 32'(pb) << w | 1 << (nb - 1));
			do bus(1'b0, 8'h28, 32'h0, rd); while (rd[0] !== 1'b0);
		end
		$display("frame formats done");
		wr(8'h00, 32'h0000_0803);
		wr(8'h08, 32'h0000_0A0D);
		for (int i = 0; i < 3; i++) begin
			d = (i == 2) ? 32'h0D : 32'h41 + i;
			exp_q.push_back(d);
			dev_u.send(d[7:0]);
		end
		repeat (100) @(posedge hclk);
		chk(got, 0);
		exp_q.push_back(32'h0A);
		dev_u.send(8'h0A);
		for (int i = 0; i < 2000 && got < 4; i++) @(posedge hclk);
		chk(got, 4);
		$display("delimiter done");
		for (int i = 0; i < DEPTH; i++) begin
			d = rnd() & 32'h7F | 32'h20;
			if (i == DEPTH - 1) chk(got, 4);
			exp_q.push_back(d);
			dev_u.send(d[7:0]);
		end
		for (int i = 0; i < 2000 && got < 20; i++) @(posedge hclk);
		chk(got, 20);
		wr(8'h08, 32'h0);
		wr(8'h10, 32'h3);
		exp_q.push_back(32'h55);
		dev_u.send(8'h55);
		for (int i = 0; i < 300 && got < 21; i++) @(posedge hclk);
		chk(got, 21);
		$display("full and flush done");
		wr(8'h18, 32'h5);
		dev_u.nb = 9;
		put(8'h3C);
		for (int i = 0; i < 2000 && dev_u.n_rx < 6; i++) @(posedge hclk);
		chk(dev_u.rx_q.pop_front(), 32'h13C);
		sess_active <= 1'b1;
		wr(8'h20, 32'h1);
		for (int i = 0; i < 100 && alive_probe !== 1'b1; i++) @(posedge hclk);
		chk(32'(alive_probe), 32'h1);
		alive_fail <= 1'b1;
		@(posedge hclk);
		alive_fail <= 1'b0;
		for (int i = 0; i < 20 && sess_close !== 1'b1; i++) @(posedge hclk);
		chk(32'(sess_close), 32'h1);
		sess_active <= 1'b0;
		wr(8'h20, 32'h0);
		wr(8'h1C, 32'h2);
		sess_active <= 1'b1;
		for (w = 0; w < 100 && sess_close !== 1'b1; w++) @(posedge hclk);
		chk(32'(w >= 10 && w < 40), 32'h1);
		$display("forced send and session done");
		give_verdict();
	end
endmodule
bind sdp_top sdp_props #(.DEPTH(DEPTH)) chk_u (.hclk(hclk),
	.hresetn(hresetn), .txd(txd), .txd_oe(txd_oe), .rxd_en(rxd_en),
	.rts(rts), .dtr(dtr), .net_out(net_out), .net_out_ready(net_out_ready),
	.sess_close(sess_close), .alive_probe(alive_probe),
	.sess_max(sess_max));
`default_nettype wire
